// ==== rtl/pwsc_reg.sv ====
`timescale 1ns/10ps
`default_nettype none
module pwsc_reg (
  // Clock and resets
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_sys_rst_n,
  // Register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Analog and power controller status
  input  wire logic       i_warn_cmp,
  input  wire logic       i_deep_wake,
  // Controls to comparators and stop logic
  output logic            o_detect_voltage_select,
  output logic            o_warning_voltage_select,
  output logic            o_stop_depth_control
);
  import pwsc_pkg::*;

  // ==========================================================
  // Reset release and pin synchronisers
  logic rst_sync_n;
  logic sys_sync_n;
  logic warn_s;
  logic wake_s;

  pwsc_sync u_por_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_async (1'b1),
    .o_sync  (rst_sync_n)
  );

  // Secondary reset is itself cleared by power-on reset
  pwsc_sync u_sys_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_async (i_sys_rst_n),
    .o_sync  (sys_sync_n)
  );

  pwsc_sync u_warn_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (rst_sync_n),
    .i_async (i_warn_cmp),
    .o_sync  (warn_s)
  );

  pwsc_sync u_wake_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (rst_sync_n),
    .i_async (i_deep_wake),
    .o_sync  (wake_s)
  );

  // ==========================================================
  // State
  typedef struct packed {
    logic       supply_warning_flag;
    logic       detect_voltage_select;
    logic       warning_voltage_select;
    logic       deep_stop_wake_flag;
    logic       stop_depth_control;
    logic       depth_locked;
    logic [7:0] rdata;
  } pwsc_state_t;

  pwsc_state_t st_q;
  pwsc_state_t st_d;
  logic        wr_hit;
  logic        rd_hit;
  logic [7:0]  view;

  assign wr_hit = i_wr && (i_addr == PWSC_ADDR_REG);
  assign rd_hit = i_rd && (i_addr == PWSC_ADDR_REG);

  // Read view; ack positions and bit 1 stay zero
  always_comb begin
    view = 8'h00;
    view[PWSC_BIT_WARN_FLAG] = st_q.supply_warning_flag;
    view[PWSC_BIT_DET_SEL]   = st_q.detect_voltage_select;
    view[PWSC_BIT_WARN_SEL]  = st_q.warning_voltage_select;
    view[PWSC_BIT_DEEP_FLAG] = st_q.deep_stop_wake_flag;
    view[PWSC_BIT_DEPTH]     = st_q.stop_depth_control;
  end

  // Next state; hardware set beats software clear
  always_comb begin
    st_d = st_q;
    st_d.rdata = rd_hit ? view : 8'h00;
    // Warning flag: ack only clears when comparator is quiet
    if (wr_hit && i_wdata[PWSC_BIT_WARN_ACK] && !warn_s) begin
      st_d.supply_warning_flag = 1'b0;
    end
    if (warn_s) begin
      st_d.supply_warning_flag = 1'b1;
    end
    // Deep stop wake flag
    if (wr_hit && i_wdata[PWSC_BIT_DEEP_ACK]) begin
      st_d.deep_stop_wake_flag = 1'b0;
    end
    if (wake_s) begin
      st_d.deep_stop_wake_flag = 1'b1;
    end
    if (wr_hit) begin
      st_d.detect_voltage_select  = i_wdata[PWSC_BIT_DET_SEL];
      st_d.warning_voltage_select = i_wdata[PWSC_BIT_WARN_SEL];
      // Only the first write after reset reaches the depth bit
      if (!st_q.depth_locked) begin
        st_d.stop_depth_control = i_wdata[PWSC_BIT_DEPTH];
        st_d.depth_locked       = 1'b1;
      end
    end
  end

  // Power-on clears everything; a system reset keeps the selects
  always_ff @(posedge i_mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_q <= '0;
    end else if (!sys_sync_n) begin
      st_q.supply_warning_flag <= PWSC_RESET_VALUE[7];
      st_q.deep_stop_wake_flag <= PWSC_RESET_VALUE[3];
      st_q.stop_depth_control  <= PWSC_RESET_VALUE[0];
      st_q.depth_locked        <= 1'b0;
      st_q.rdata               <= 8'h00;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_rdata                  = st_q.rdata;
  assign o_detect_voltage_select  = st_q.detect_voltage_select;
  assign o_warning_voltage_select = st_q.warning_voltage_select;
  assign o_stop_depth_control     = st_q.stop_depth_control;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!rst_sync_n || !sys_sync_n);

  AST_WARN_SET: assert property (warn_s |=> st_q.supply_warning_flag)
    else $error("warning flag not set by comparator");
  AST_WARN_STICKY: assert property (
    st_q.supply_warning_flag && !(wr_hit && i_wdata[PWSC_BIT_WARN_ACK])
    |=> st_q.supply_warning_flag)
    else $error("warning flag dropped without ack");
  AST_WARN_ACK: assert property (
    wr_hit && i_wdata[PWSC_BIT_WARN_ACK] && !warn_s
    |=> !st_q.supply_warning_flag)
    else $error("warning ack did not clear flag");
  AST_DET_SEL: assert property (
    wr_hit |=> o_detect_voltage_select == $past(i_wdata[5]))
    else $error("detect select not written");
  AST_WARN_SEL: assert property (
    wr_hit |=> o_warning_voltage_select == $past(i_wdata[4]))
    else $error("warning select not written");
  AST_WAKE_SET: assert property (wake_s |=> st_q.deep_stop_wake_flag)
    else $error("deep wake flag not set");
  AST_WAKE_ACK: assert property (
    wr_hit && i_wdata[PWSC_BIT_DEEP_ACK] && !wake_s
    |=> !st_q.deep_stop_wake_flag)
    else $error("deep wake ack did not clear flag");
  AST_DEPTH_ONCE: assert property (
    st_q.depth_locked |=> $stable(o_stop_depth_control))
    else $error("stop depth changed after first write");
  AST_DEPTH_FIRST: assert property (
    wr_hit && !st_q.depth_locked
    |=> o_stop_depth_control == $past(i_wdata[0]))
    else $error("first depth write lost");
  AST_READ_ZERO: assert property (
    rd_hit |=> (o_rdata & 8'h46) == 8'h00)
    else $error("ack or unused bit read nonzero");

  CV_WARN_ACK: cover property (st_q.supply_warning_flag ##1
    !st_q.supply_warning_flag);
  CV_WAKE: cover property (wake_s ##1 st_q.deep_stop_wake_flag);
  CV_DEPTH_IGN: cover property (wr_hit && st_q.depth_locked);
endmodule
`default_nettype wire

// ==== rtl/pwsc_pkg.sv ====
package pwsc_pkg;
  // ==========================================================
  // Register layout
  localparam logic [7:0] PWSC_ADDR_REG      = 8'h00;
  localparam int         PWSC_BIT_WARN_FLAG = 7;
  localparam int         PWSC_BIT_WARN_ACK  = 6;
  localparam int         PWSC_BIT_DET_SEL   = 5;
  localparam int         PWSC_BIT_WARN_SEL  = 4;
  localparam int         PWSC_BIT_DEEP_FLAG = 3;
  localparam int         PWSC_BIT_DEEP_ACK  = 2;
  localparam int         PWSC_BIT_DEPTH     = 0;
  localparam logic [7:0] PWSC_RESET_VALUE   = 8'h00;
  // Number of flops in the pin synchroniser
  localparam int         PWSC_SYNC_STAGES   = 2;
endpackage

// ==== rtl/pwsc_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Two-flop level synchroniser for asynchronous pin inputs
module pwsc_sync (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  // Level in and out
  input  wire logic i_async,
  output logic      o_sync
);
  import pwsc_pkg::*;

  typedef struct packed {
    logic [PWSC_SYNC_STAGES-1:0] stage;
  } pwsc_sync_t;

  pwsc_sync_t s_q;
  pwsc_sync_t s_d;

  // Shift chain; only the last stage is ever read
  always_comb begin
    s_d = s_q;
    s_d.stage = {s_q.stage[PWSC_SYNC_STAGES-2:0], i_async};
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_sync = s_q.stage[PWSC_SYNC_STAGES-1];
endmodule
`default_nettype wire

// ==== tb/pwsc_reg_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Bench for the power warning and stop control register
module pwsc_reg_tb_top;
  import pwsc_pkg::*;
  logic       i_mclk, i_rst_n, i_sys_rst_n, i_wr, i_rd;
  logic       i_warn_cmp, i_deep_wake;
  logic [7:0] i_addr, i_wdata, o_rdata;
  logic       o_det, o_warn, o_depth;
  int         mismatches, checked;

  pwsc_reg uut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sys_rst_n(i_sys_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_warn_cmp(i_warn_cmp),
    .i_deep_wake(i_deep_wake), .o_detect_voltage_select(o_det),
    .o_warning_voltage_select(o_warn), .o_stop_depth_control(o_depth)
  );

  // ==========================================================
  // Free-running 125 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  // ==========================================================
  // Shared helpers
  task automatic chk(input string n, input logic [7:0] e, g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  // Read data is only valid in the cycle after the strobe
  task automatic rd(input logic [7:0] e, input string n);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= PWSC_ADDR_REG;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 chk(n, e, o_rdata);
  endtask
  // Flags take 3 cycles from pin; wait a little longer
  // Pin select: 0 comparator, 1 wake, 2 system reset, else power-on
  task automatic pin(input int w, input logic v);
    @(posedge i_mclk);
    case (w)
      0: i_warn_cmp <= v;
      1: i_deep_wake <= v;
      2: i_sys_rst_n <= v;
      default: i_rst_n <= v;
    endcase
    repeat (5) @(posedge i_mclk);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rd(8'h00, "reset value");
    wr(PWSC_ADDR_REG, 8'h33);
    rd(8'h31, "rw bits");
    chk("outs", 8'h07, {5'h0, o_det, o_warn, o_depth});
    wr(PWSC_ADDR_REG, 8'h10);
    wr(8'h05, 8'h20);
    rd(8'h11, "depth locked");
    chk("depth out", 8'h01, {7'h0, o_depth});
    $display("test regs done");
  endtask
  task automatic t_warn;
    pin(0, 1'b1);
    rd(8'h91, "warn set");
    wr(PWSC_ADDR_REG, 8'h50);
    rd(8'h91, "ack refused");
    pin(0, 1'b0);
    rd(8'h91, "warn sticky");
    wr(PWSC_ADDR_REG, 8'h50);
    rd(8'h11, "warn cleared");
    $display("test warn done");
  endtask
  task automatic t_deep;
    pin(1, 1'b1);
    pin(1, 1'b0);
    rd(8'h19, "wake set");
    wr(PWSC_ADDR_REG, 8'h10);
    rd(8'h19, "zero ack");
    wr(PWSC_ADDR_REG, 8'h14);
    rd(8'h11, "wake cleared");
    $display("test deep done");
  endtask
  // Supply still low across a system reset must re-set the flag
  task automatic t_resets;
    pin(0, 1'b1);
    pin(2, 1'b0);
    pin(2, 1'b1);
    rd(8'h90, "sys reset");
    pin(0, 1'b0);
    wr(PWSC_ADDR_REG, 8'h51);
    rd(8'h11, "rewrite depth");
    pin(3, 1'b0);
    pin(3, 1'b1);
    rd(8'h00, "power on");
    chk("outs por", 8'h00, {5'h0, o_det, o_warn, o_depth});
    $display("test resets done");
  endtask

  // ==========================================================
  // Verdict, reached from the main sequence or the watchdog
  task automatic results;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge i_mclk);
    mismatches++;
    results;
  end

  initial begin
    {i_rst_n, i_sys_rst_n, i_wr, i_rd} = 4'h4;
    {i_warn_cmp, i_deep_wake, i_addr, i_wdata} = 18'h0;
    repeat (16) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_mclk);
    t_regs;
    t_warn;
    t_deep;
    t_resets;
    results;
  end
endmodule
`default_nettype wire
